// ### prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
// register file offsets
`define PRS_OFS_CMD          3'h0
`define PRS_OFS_BLOCK        3'h1
`define PRS_OFS_PARAM0       3'h2
`define PRS_OFS_PARAM1       3'h3
`define PRS_OFS_PARAM2       3'h4
`define PRS_OFS_PARAM3       3'h5
`define PRS_OFS_PARAM4       3'h6
`define PRS_OFS_PARAM5       3'h7
`define PRS_OFS_TRANS        3'h2
`define PRS_OFS_PSUPP        3'h3
`define PRS_OFS_PKTNUM       3'h7
// command codes
`define PRS_CMD_READ_STATUS  8'hb8
`define PRS_CMD_RESUME       8'hb7
`define PRS_CMD_ACK          8'h02
// interface state bit positions
`define PRS_IS_CCR           6
`define PRS_IS_SCF           5
`define PRS_IS_RFB           3
`define PRS_IS_BTR           2
`define PRS_IS_BTD           1
`define PRS_IS_BTT           0
// result codes
`define PRS_TS_GOOD          8'h00
`define PRS_TS_REJECT        8'h01
`define PRS_TS_PKT_FATAL     8'h29
`define PRS_SUPP_NONE        8'hfe
`define PRS_SUPP_BAD_ID      8'h01
`define PRS_SUPP_BAD_PARAM   8'h02
// packet fields
`define PRS_ID_MAX           8'h3f
`define PRS_ID_SUPPORTED     8'h00
`define PRS_SIDE_DEST        2'h0
`define PRS_SIDE_NONE        2'h2
`define PRS_SIDE_SRC         2'h3
`define PRS_ADDR_DEFAULT     24'hffffff
`define PRS_BLOCK_LEN        6'd36
`define PRS_STEP_FIRST       8'h01
// timing: resumable packet retires after this many minutes
`define PRS_TIMEOUT_MIN      64'd15
`define PRS_CLK_PERIOD_NS    64'd10
`define PRS_TIMEOUT_CYC      (`PRS_TIMEOUT_MIN * 64'd60 * 64'd1000000000 / `PRS_CLK_PERIOD_NS)
`endif

// ### prs_pkg.sv
package prs_pkg;
  typedef enum logic [7:0] {
    PRS_PK_NONE      = 8'h00,
    PRS_PK_RECEIVING = 8'h01,
    PRS_PK_EXECUTING = 8'h02,
    PRS_PK_WAITING   = 8'h03,
    PRS_PK_RESUMING  = 8'h04,
    PRS_PK_PREP_WAIT = 8'h05,
    PRS_PK_TERMINATE = 8'h06,
    PRS_PK_ABORTED   = 8'h0a,
    PRS_PK_COMPLETED = 8'h0d
  } prs_pkt_state_e;

  typedef enum logic [1:0] {
    PRS_IF_IDLE   = 2'b00,
    PRS_IF_BLOCK  = 2'b01,
    PRS_IF_DONE   = 2'b10
  } prs_if_state_e;

  typedef logic [7:0] prs_byte_t;
endpackage

// ### prs_unit.sv
`timescale 1ns/10ps
`include "prs_cfg.svh"

// How it works
// - resume restarts suspended packet from buffer
// - valid resume posts nothing; illegal posts completion
// - rejected resume leaves packet state untouched
// - packet number 00..3f, only zero exists
// - all-ff address resumes at stored location
// - streaming tape ignores resume address
// - side flag 0 destination, 3 source
// - side flag ignored when address all ff
// - code b8 sends status block to host
// - reject status read for bad packet number
// - rejection sets defined supplemental code
// - packet state byte reports state codes
// - abort or 15 minute wait gives aborted
// - termination side 0 dest, 3 src, 2 none
// - primary status copies terminating device status
// - supplemental is fe when none given
// - packet offset, msb first
// - packet length, msb first
// - block carries current step operation code
// - step number starts one, counts completed steps
// - copied total advances on output completion
module prs_unit #(
  parameter logic [39:0] TIMEOUT_CYC = 40'(`PRS_TIMEOUT_CYC)
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // register file port
  input  wire logic [2:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // packet engine events
  input  wire logic              i_eng_state_set,
  input  wire prs_pkg::prs_pkt_state_e i_eng_state,
  input  wire logic [15:0]       i_pkt_offset,
  input  wire logic [15:0]       i_pkt_length,
  input  wire logic              i_step_start,
  input  wire logic [7:0]        i_step_opcode,
  input  wire logic              i_step_done,
  input  wire logic              i_out_done,
  input  wire logic [15:0]       i_out_count,
  input  wire logic              i_term,
  input  wire logic [1:0]        i_term_side,
  input  wire logic [7:0]        i_term_status,
  input  wire logic              i_term_has_supp,
  input  wire logic [7:0]        i_term_supp,
  input  wire logic              i_abort,
  input  wire logic              i_dev_update,
  input  wire logic              i_dev_is_src,
  input  wire logic [7:0]        i_dev_select,
  input  wire logic [7:0]        i_dev_status,
  input  wire logic [7:0]        i_dev_supp,
  input  wire logic [23:0]       i_dev_addr,
  input  wire logic [31:0]       i_dev_count,
  input  wire logic              i_src_is_tape,
  input  wire logic              i_dst_is_tape,
  // resume request to the packet engine
  output logic                   o_resume_go,
  output logic                   o_resume_use_addr,
  output logic [1:0]             o_resume_side,
  output logic [23:0]            o_resume_addr,
  output prs_pkg::prs_pkt_state_e o_pkt_state
);
  import prs_pkg::*;

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  prs_byte_t         param_r [0:5];
  prs_byte_t         param_nxt [0:5];
  prs_byte_t         cmd_r, cmd_nxt;
  logic              cmd_pend_r, cmd_pend_nxt;
  logic              ccr_r, ccr_nxt;
  prs_byte_t         trans_r, trans_nxt;
  prs_byte_t         psupp_r, psupp_nxt;
  prs_byte_t         pktnum_r, pktnum_nxt;
  prs_byte_t         rdata_r, rdata_nxt;
  prs_if_state_e     if_r, if_nxt;
  logic [5:0]        idx_r, idx_nxt;
  logic              go_r, go_nxt;
  logic              use_addr_r, use_addr_nxt;
  logic [1:0]        rside_r, rside_nxt;
  logic [23:0]       raddr_r, raddr_nxt;

  // ------------------------------------------------------------------
  // packet status store
  // ------------------------------------------------------------------
  prs_pkt_state_e    pst_r, pst_nxt;
  logic [1:0]        tside_r, tside_nxt;
  prs_byte_t         tstat_r, tstat_nxt;
  prs_byte_t         tsupp_r, tsupp_nxt;
  logic [15:0]       poff_r, poff_nxt;
  logic [15:0]       plen_r, plen_nxt;
  prs_byte_t         opc_r, opc_nxt;
  prs_byte_t         step_r, step_nxt;
  logic [31:0]       copied_r, copied_nxt;
  logic [7:0]        dsel_r [0:1];
  logic [7:0]        dsel_nxt [0:1];
  logic [7:0]        dst_r [0:1];
  logic [7:0]        dst_nxt [0:1];
  logic [7:0]        dsp_r [0:1];
  logic [7:0]        dsp_nxt [0:1];
  logic [23:0]       dad_r [0:1];
  logic [23:0]       dad_nxt [0:1];
  logic [31:0]       dcnt_r [0:1];
  logic [31:0]       dcnt_nxt [0:1];
  logic [39:0]       age_r, age_nxt;

  logic              id_ok;
  logic              addr_dflt;
  logic              flag_ok;
  logic              is_status_cmd;
  logic              is_resume_cmd;
  logic              blk_rd;
  prs_byte_t         blk_byte;
  prs_byte_t         ifstat;

  assign id_ok         = (param_r[0] <= `PRS_ID_MAX) && (param_r[0] == `PRS_ID_SUPPORTED);
  assign addr_dflt     = ({param_r[2], param_r[3], param_r[4]} == `PRS_ADDR_DEFAULT);
  assign flag_ok       = (param_r[1][1:0] == `PRS_SIDE_DEST) || (param_r[1][1:0] == `PRS_SIDE_SRC);
  assign is_status_cmd = cmd_pend_r && (cmd_r == `PRS_CMD_READ_STATUS);
  assign is_resume_cmd = cmd_pend_r && (cmd_r == `PRS_CMD_RESUME);
  assign blk_rd        = i_rd && (i_addr == `PRS_OFS_BLOCK) && (if_r == PRS_IF_BLOCK);

  assign ifstat = {1'b0, ccr_r, 1'b0, 1'b0, cmd_pend_r,
                   (if_r == PRS_IF_BLOCK), (if_r == PRS_IF_BLOCK), 1'b0};

  // ------------------------------------------------------------------
  // status block byte selector
  // ------------------------------------------------------------------
  function automatic prs_byte_t blk_sel(input logic [5:0] i);
    logic [0:0] d;
    logic [3:0] k;
    d = 1'b0;
    k = 4'h0;
    if (i >= 6'd26) begin
      d = 1'b1;
      k = 4'(i - 6'd26);
    end else if (i >= 6'd16) begin
      k = 4'(i - 6'd16);
    end
    blk_sel = 8'h00;
    if (i >= 6'd16) begin
      unique case (k)
        4'h0: blk_sel = dsel_r[d];
        4'h1: blk_sel = dst_r[d];
        4'h2: blk_sel = dsp_r[d];
        4'h3: blk_sel = dad_r[d][23:16];
        4'h4: blk_sel = dad_r[d][15:8];
        4'h5: blk_sel = dad_r[d][7:0];
        4'h6: blk_sel = dcnt_r[d][31:24];
        4'h7: blk_sel = dcnt_r[d][23:16];
        4'h8: blk_sel = dcnt_r[d][15:8];
        4'h9: blk_sel = dcnt_r[d][7:0];
        default: blk_sel = 8'h00;
      endcase
    end else begin
      unique case (i[3:0])
        4'h0: blk_sel = pktnum_r;
        4'h1: blk_sel = pst_r;
        4'h2: blk_sel = {6'h00, tside_r};
        4'h3: blk_sel = tstat_r;
        4'h4: blk_sel = tsupp_r;
        4'h5: blk_sel = 8'h00;
        4'h6: blk_sel = poff_r[15:8];
        4'h7: blk_sel = poff_r[7:0];
        4'h8: blk_sel = plen_r[15:8];
        4'h9: blk_sel = plen_r[7:0];
        4'ha: blk_sel = opc_r;
        4'hb: blk_sel = step_r;
        4'hc: blk_sel = copied_r[31:24];
        4'hd: blk_sel = copied_r[23:16];
        4'he: blk_sel = copied_r[15:8];
        4'hf: blk_sel = copied_r[7:0];
        default: blk_sel = 8'h00;
      endcase
    end
  endfunction

  // a continuous assign would not follow the stored fields the function reads
  always_comb begin
    blk_byte = blk_sel(idx_r);
  end

  // ------------------------------------------------------------------
  // host command and register file
  // ------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      param_nxt[p] = param_r[p];
    end
    cmd_nxt      = cmd_r;
    cmd_pend_nxt = 1'b0;
    ccr_nxt      = ccr_r;
    trans_nxt    = trans_r;
    psupp_nxt    = psupp_r;
    pktnum_nxt   = pktnum_r;
    if_nxt       = if_r;
    idx_nxt      = idx_r;
    go_nxt       = 1'b0;
    use_addr_nxt = use_addr_r;
    rside_nxt    = rside_r;
    raddr_nxt    = raddr_r;
    rdata_nxt    = rdata_r;

    if (i_wr && (i_addr >= `PRS_OFS_PARAM0)) begin
      param_nxt[3'(i_addr - `PRS_OFS_PARAM0)] = i_wdata;
    end
    if (i_wr && (i_addr == `PRS_OFS_CMD)) begin
      cmd_nxt      = i_wdata;
      cmd_pend_nxt = 1'b1;
      if (i_wdata == `PRS_CMD_ACK) begin
        ccr_nxt = 1'b0;
      end
    end

    if (i_rd) begin
      unique case (i_addr)
        `PRS_OFS_CMD:    rdata_nxt = ifstat;
        `PRS_OFS_BLOCK:  rdata_nxt = (if_r == PRS_IF_BLOCK) ? blk_byte : 8'h00;
        `PRS_OFS_TRANS:  rdata_nxt = trans_r;
        `PRS_OFS_PSUPP:  rdata_nxt = psupp_r;
        `PRS_OFS_PKTNUM: rdata_nxt = pktnum_r;
        default:         rdata_nxt = 8'h00;
      endcase
    end

    if (blk_rd) begin
      if (idx_r == `PRS_BLOCK_LEN - 6'd1) begin
        if_nxt = PRS_IF_DONE;
      end else begin
        idx_nxt = idx_r + 6'd1;
      end
    end
    if (if_r == PRS_IF_DONE) begin
      if_nxt    = PRS_IF_IDLE;
      ccr_nxt   = 1'b1;
      trans_nxt = `PRS_TS_GOOD;
      psupp_nxt = `PRS_SUPP_NONE;
    end

    // host keeps off during host steps
    if (is_status_cmd) begin
      pktnum_nxt = param_r[0];
      if (id_ok && (pst_r != PRS_PK_NONE)) begin
        if_nxt  = PRS_IF_BLOCK;
        idx_nxt = 6'd0;
      end else begin
        ccr_nxt   = 1'b1;
        trans_nxt = `PRS_TS_REJECT;
        psupp_nxt = `PRS_SUPP_BAD_ID;
      end
    end

    if (is_resume_cmd) begin
      pktnum_nxt = param_r[0];
      if (id_ok && (pst_r == PRS_PK_WAITING) && (addr_dflt || flag_ok)) begin
        go_nxt       = 1'b1;
        use_addr_nxt = !addr_dflt &&
                       !((param_r[1][1:0] == `PRS_SIDE_SRC) ? i_src_is_tape : i_dst_is_tape);
        rside_nxt    = addr_dflt ? `PRS_SIDE_NONE : param_r[1][1:0];
        raddr_nxt    = {param_r[2], param_r[3], param_r[4]};
      end else begin
        ccr_nxt   = 1'b1;
        trans_nxt = `PRS_TS_PKT_FATAL;
        psupp_nxt = `PRS_SUPP_BAD_PARAM;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 6; p++) begin
        param_r[p] <= 8'h00;
      end
      cmd_r      <= 8'h00;
      cmd_pend_r <= 1'b0;
      ccr_r      <= 1'b0;
      trans_r    <= 8'h00;
      psupp_r    <= 8'h00;
      pktnum_r   <= 8'h00;
      if_r       <= PRS_IF_IDLE;
      idx_r      <= 6'd0;
      go_r       <= 1'b0;
      use_addr_r <= 1'b0;
      rside_r    <= `PRS_SIDE_NONE;
      raddr_r    <= 24'h000000;
      rdata_r    <= 8'h00;
    end else if (i_ce) begin
      for (int p = 0; p < 6; p++) begin
        param_r[p] <= param_nxt[p];
      end
      cmd_r      <= cmd_nxt;
      cmd_pend_r <= cmd_pend_nxt;
      ccr_r      <= ccr_nxt;
      trans_r    <= trans_nxt;
      psupp_r    <= psupp_nxt;
      pktnum_r   <= pktnum_nxt;
      if_r       <= if_nxt;
      idx_r      <= idx_nxt;
      go_r       <= go_nxt;
      use_addr_r <= use_addr_nxt;
      rside_r    <= rside_nxt;
      raddr_r    <= raddr_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------------
  // packet progress tracking
  // ------------------------------------------------------------------
  always_comb begin
    pst_nxt    = pst_r;
    tside_nxt  = tside_r;
    tstat_nxt  = tstat_r;
    tsupp_nxt  = tsupp_r;
    poff_nxt   = poff_r;
    plen_nxt   = plen_r;
    opc_nxt    = opc_r;
    step_nxt   = step_r;
    copied_nxt = copied_r;
    age_nxt    = 40'd0;
    for (int d = 0; d < 2; d++) begin
      dsel_nxt[d] = dsel_r[d];
      dst_nxt[d]  = dst_r[d];
      dsp_nxt[d]  = dsp_r[d];
      dad_nxt[d]  = dad_r[d];
      dcnt_nxt[d] = dcnt_r[d];
    end

    if (i_eng_state_set) begin
      pst_nxt = i_eng_state;
      if (i_eng_state == PRS_PK_RECEIVING) begin
        poff_nxt   = i_pkt_offset;
        plen_nxt   = i_pkt_length;
        step_nxt   = `PRS_STEP_FIRST;
        copied_nxt = 32'd0;
        tside_nxt  = `PRS_SIDE_NONE;
        tsupp_nxt  = `PRS_SUPP_NONE;
      end
    end
    if (i_step_start) begin
      opc_nxt = i_step_opcode;
    end
    if (i_step_done) begin
      step_nxt = step_nxt + 8'h01;
    end
    if (i_out_done) begin
      copied_nxt = copied_r + 32'(i_out_count);
    end
    if (i_term) begin
      tside_nxt = i_term_side;
      tstat_nxt = i_term_status;
      tsupp_nxt = i_term_has_supp ? i_term_supp : `PRS_SUPP_NONE;
    end
    if (i_dev_update) begin
      dsel_nxt[!i_dev_is_src] = i_dev_select;
      dst_nxt[!i_dev_is_src]  = i_dev_status;
      dsp_nxt[!i_dev_is_src]  = i_dev_supp;
      dad_nxt[!i_dev_is_src]  = i_dev_addr;
      dcnt_nxt[!i_dev_is_src] = i_dev_count;
    end

    // failed resume leaves state as is
    if (go_r) begin
      pst_nxt = PRS_PK_RESUMING;
    end

    if (pst_r == PRS_PK_WAITING) begin
      age_nxt = age_r + 40'd1;
    end
    if (i_abort || ((pst_r == PRS_PK_WAITING) && (age_r >= TIMEOUT_CYC - 40'd1))) begin
      pst_nxt = PRS_PK_ABORTED;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pst_r    <= PRS_PK_NONE;
      tside_r  <= `PRS_SIDE_NONE;
      tstat_r  <= 8'h00;
      tsupp_r  <= `PRS_SUPP_NONE;
      poff_r   <= 16'h0000;
      plen_r   <= 16'h0000;
      opc_r    <= 8'h00;
      step_r   <= `PRS_STEP_FIRST;
      copied_r <= 32'h00000000;
      age_r    <= 40'd0;
      for (int d = 0; d < 2; d++) begin
        dsel_r[d] <= 8'h00;
        dst_r[d]  <= 8'h00;
        dsp_r[d]  <= `PRS_SUPP_NONE;
        dad_r[d]  <= 24'h000000;
        dcnt_r[d] <= 32'h00000000;
      end
    end else if (i_ce) begin
      pst_r    <= pst_nxt;
      tside_r  <= tside_nxt;
      tstat_r  <= tstat_nxt;
      tsupp_r  <= tsupp_nxt;
      poff_r   <= poff_nxt;
      plen_r   <= plen_nxt;
      opc_r    <= opc_nxt;
      step_r   <= step_nxt;
      copied_r <= copied_nxt;
      age_r    <= age_nxt;
      for (int d = 0; d < 2; d++) begin
        dsel_r[d] <= dsel_nxt[d];
        dst_r[d]  <= dst_nxt[d];
        dsp_r[d]  <= dsp_nxt[d];
        dad_r[d]  <= dad_nxt[d];
        dcnt_r[d] <= dcnt_nxt[d];
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_rdata           = rdata_r;
  assign o_resume_go       = go_r;
  assign o_resume_use_addr = use_addr_r;
  assign o_resume_side     = rside_r;
  assign o_resume_addr     = raddr_r;
  assign o_pkt_state       = pst_r;
endmodule

// ### prs_unit_monitor.sv
`timescale 1ns/10ps
module prs_unit_monitor
  import prs_pkg::*;
#(
  parameter logic [39:0] TIMEOUT_CYC = 40'd20
) (
  input wire logic           i_clk_sys,
  input wire logic           i_rst_n,
  input wire logic           i_ce,
  input wire logic [2:0]     i_addr,
  input wire logic           i_rd,
  input wire logic           i_abort,
  input wire logic           i_src_is_tape,
  input wire logic           i_dst_is_tape,
  input wire logic [7:0]     o_rdata,
  input wire logic           o_resume_go,
  input wire logic           o_resume_use_addr,
  input wire logic [1:0]     o_resume_side,
  input wire logic [23:0]    o_resume_addr,
  input wire prs_pkt_state_e o_pkt_state
);
  // ---------------------------------
  // age of the waiting state
  // ---------------------------------
  logic [39:0] age_r;
  logic [39:0] age_nxt;

  always_comb begin
    age_nxt = age_r;
    if (i_ce) begin
      age_nxt = (o_pkt_state == PRS_PK_WAITING) ? age_r + 40'h1 : 40'h0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    age_r <= i_rst_n ? age_nxt : 40'h0;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_go_pulse: assert property (
    o_resume_go && i_ce |=> !o_resume_go) else $error("resume go wider than one cycle");
  a_go_resuming: assert property (
    o_resume_go && i_ce && !i_abort |=> o_pkt_state == PRS_PK_RESUMING) else $error("no resuming state");
  a_go_from_wait: assert property (
    o_resume_go |-> $past(o_pkt_state) == PRS_PK_WAITING) else $error("resume of a packet not waiting");
  a_abort_state: assert property (
    i_abort && i_ce |=> o_pkt_state == PRS_PK_ABORTED) else $error("abort not taken");
  a_ff_side: assert property (
    o_resume_go && o_resume_addr == 24'hffffff |-> o_resume_side == 2'h2 && !o_resume_use_addr)
    else $error("all ones address used");
  a_tape_addr: assert property (
    o_resume_go && o_resume_use_addr |-> (o_resume_side == 2'h3 && !i_src_is_tape) ||
                                         (o_resume_side == 2'h0 && !i_dst_is_tape))
    else $error("address applied to tape or bad side");
  a_hole_read: assert property (
    i_rd && i_ce && i_addr inside {3'h4, 3'h5, 3'h6} |=> o_rdata == 8'h00) else $error("hole not zero");
  a_wait_age: assert property (
    age_r <= TIMEOUT_CYC + 40'h1) else $error("waiting packet not retired");
endmodule

bind prs_unit prs_unit_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_prs_unit_monitor (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd),
  .i_abort(i_abort), .i_src_is_tape(i_src_is_tape), .i_dst_is_tape(i_dst_is_tape),
  .o_rdata(o_rdata), .o_resume_go(o_resume_go), .o_resume_use_addr(o_resume_use_addr),
  .o_resume_side(o_resume_side), .o_resume_addr(o_resume_addr), .o_pkt_state(o_pkt_state));

// ### prs_host_model.sv
`timescale 1ns/10ps
module prs_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic      [2:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // ---------------------------------
  // register file cycles
  // ---------------------------------
  // one strobe per call, never both
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    // data lines flip once released so a stale value cannot match
    o_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// ### packet_resume_status_unit_tb_top.sv
`timescale 1ns/10ps
`include "prs_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module packet_resume_status_unit_tb_top;
  import prs_pkg::*;
  localparam int TO_CYC = 200;
  localparam logic [6:0] E_SET = 7'h01, E_STEP = 7'h02, E_DONE = 7'h04, E_OUT = 7'h08;
  localparam logic [6:0] E_TERM = 7'h10, E_ABORT = 7'h20, E_DEV = 7'h40;
  int n_mismatch = 0;
  int comparisons = 0;
  logic clk = 1'b0, rst_n = 1'b0, thas = 1'b0, dsrc = 1'b0, src_tape = 1'b0, dst_tape = 1'b0, ce = 1'b1;
  logic [6:0] ev = '0;
  prs_pkt_state_e st = PRS_PK_NONE, pst;
  logic [15:0] off = '0, len = '0, cnt = '0;
  logic [7:0] op = '0, tstat = '0, tsupp = '0, dsel = '0, dstat = '0, dsupp = '0, wdata, rdata;
  logic [1:0] tside = '0, side;
  logic [23:0] daddr = '0, raddr;
  logic [31:0] dcnt = '0;
  logic [2:0] addr;
  logic wr, rd, go, use_a;

  prs_unit #(.TIMEOUT_CYC(40'(TO_CYC))) i_prs_unit (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_eng_state_set(ev[0]), .i_eng_state(st), .i_pkt_offset(off),
    .i_pkt_length(len), .i_step_start(ev[1]), .i_step_opcode(op), .i_step_done(ev[2]),
    .i_out_done(ev[3]), .i_out_count(cnt), .i_term(ev[4]), .i_term_side(tside),
    .i_term_status(tstat), .i_term_has_supp(thas), .i_term_supp(tsupp), .i_abort(ev[5]),
    .i_dev_update(ev[6]), .i_dev_is_src(dsrc), .i_dev_select(dsel), .i_dev_status(dstat),
    .i_dev_supp(dsupp), .i_dev_addr(daddr), .i_dev_count(dcnt), .i_src_is_tape(src_tape),
    .i_dst_is_tape(dst_tape), .o_resume_go(go), .o_resume_use_addr(use_a), .o_resume_side(side),
    .o_resume_addr(raddr), .o_pkt_state(pst));

  prs_host_model i_prs_host_model (
    .i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  initial forever #5 clk = ~clk;

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic finish_test;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] d);
    i_prs_host_model.wr(a, d);
  endtask

  task automatic r(input logic [2:0] a, output logic [7:0] d);
    i_prs_host_model.rd(a, d);
  endtask

  task automatic pulse(input logic [6:0] m);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask

  task automatic wait_bit(input int b);
    logic [7:0] d;
    for (int k = 0; k < 20; k++) begin
      r(3'h0, d);
      if (d[b] === 1'b1) return;
    end
    `CHK(d[b], 1'b1)
    finish_test;
  endtask

  task automatic ack;
    logic [7:0] d;
    w(3'h0, `PRS_CMD_ACK);
    r(3'h0, d);
    `CHK(d[`PRS_IS_CCR], 1'b0)
  endtask

  task automatic bad_status(input logic [7:0] id);
    logic [7:0] d;
    w(3'h2, id);
    w(3'h0, `PRS_CMD_READ_STATUS);
    wait_bit(`PRS_IS_CCR);
    r(3'h2, d);
    `CHK(d, `PRS_TS_REJECT)
    r(3'h3, d);
    `CHK(d, `PRS_SUPP_BAD_ID)
    ack;
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_reset;
    logic [7:0] d;
    `CHK(pst, PRS_PK_NONE)
    r(3'h0, d);
    `CHK(d, 8'h00)
    r(3'h5, d);
    `CHK(d, 8'h00)
    bad_status(8'h00);
    $display("test reset done");
  endtask

  task automatic t_status;
    logic [7:0] d;
    logic [7:0] exp [36] = '{8'h00, 8'h0d, 8'h03, 8'h29, 8'hfe, 8'h00, 8'h01, 8'h20, 8'h00, 8'h34,
      8'h5c, 8'h03, 8'h00, 8'h00, 8'h00, 8'h08, 8'h41, 8'h51, 8'h61, 8'h12, 8'h34, 8'h01, 8'h00,
      8'h01, 8'h02, 8'h01, 8'h40, 8'h50, 8'h60, 8'h12, 8'h34, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
    st <= PRS_PK_RECEIVING;
    off <= 16'h0120;
    len <= 16'h0034;
    pulse(E_SET);
    st <= PRS_PK_EXECUTING;
    pulse(E_SET);
    op <= 8'h5c;
    pulse(E_STEP);
    pulse(E_DONE);
    pulse(E_DONE);
    cnt <= 16'h0003;
    pulse(E_OUT);
    cnt <= 16'h0005;
    pulse(E_OUT);
    tside <= 2'h3;
    tstat <= 8'h29;
    tsupp <= 8'h77;
    pulse(E_TERM);
    for (int j = 0; j < 2; j++) begin
      dsrc <= j[0];
      dsel <= 8'h40 + 8'(j);
      dstat <= 8'h50 + 8'(j);
      dsupp <= 8'h60 + 8'(j);
      daddr <= 24'h123400 + 24'(j);
      dcnt <= 32'h00010200 + 32'(j);
      pulse(E_DEV);
    end
    st <= PRS_PK_COMPLETED;
    pulse(E_SET);
    bad_status(8'h05);
    w(3'h2, 8'h00);
    w(3'h0, `PRS_CMD_READ_STATUS);
    wait_bit(`PRS_IS_BTR);
    for (int i = 0; i < 36; i++) begin
      r(3'h1, d);
      // the upper bits of byte 2 are undefined
      if (i == 2) d = d & 8'h03;
      `CHK(d, exp[i])
    end
    // results are posted one cycle after the last block byte
    @(posedge clk);
    #1;
    r(3'h0, d);
    `CHK(d[`PRS_IS_CCR], 1'b1)
    r(3'h2, d);
    `CHK(d, `PRS_TS_GOOD)
    r(3'h3, d);
    `CHK(d, `PRS_SUPP_NONE)
    ack;
    $display("test status done");
  endtask

  task automatic resume_case(input logic [7:0] id, input logic [1:0] fl, input logic [23:0] ad,
                             input logic ts, input logic td, input logic go_x, input logic use_x,
                             input logic [1:0] sd);
    logic [7:0] d;
    logic seen;
    seen = 1'b0;
    src_tape <= ts;
    dst_tape <= td;
    st <= PRS_PK_WAITING;
    pulse(E_SET);
    w(3'h2, id);
    w(3'h3, {6'h00, fl});
    w(3'h4, ad[23:16]);
    w(3'h5, ad[15:8]);
    w(3'h6, ad[7:0]);
    w(3'h0, `PRS_CMD_RESUME);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1;
      if (go === 1'b1) begin
        seen = 1'b1;
        `CHK(use_a, use_x)
        `CHK(side, sd)
        if (use_x) begin
          `CHK(raddr, ad)
        end
      end
    end
    `CHK(seen, go_x)
    if (!go_x) begin
      r(3'h0, d);
      `CHK(d[`PRS_IS_CCR], 1'b1)
      r(3'h2, d);
      `CHK(d, `PRS_TS_PKT_FATAL)
      r(3'h3, d);
      `CHK(d, `PRS_SUPP_BAD_PARAM)
      `CHK(pst, PRS_PK_WAITING)
      ack;
    end else begin
      r(3'h0, d);
      `CHK(d[`PRS_IS_CCR], 1'b0)
    end
  endtask

  task automatic t_resume;
    resume_case(8'h01, 2'h0, 24'h123456, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    resume_case(8'h00, 2'h1, 24'h123456, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    resume_case(8'h00, 2'h1, 24'hffffff, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2);
    resume_case(8'h00, 2'h3, 24'h123456, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3);
    resume_case(8'h00, 2'h0, 24'h0a0b0c, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    resume_case(8'h00, 2'h0, 24'h654321, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
    $display("test resume done");
  endtask

  task automatic t_abort_timeout;
    st <= PRS_PK_EXECUTING;
    pulse(E_SET);
    pulse(E_ABORT);
    `CHK(pst, PRS_PK_ABORTED)
    st <= PRS_PK_WAITING;
    pulse(E_SET);
    // frozen cycles must not age the waiting packet
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    ce <= 1'b1;
    repeat (TO_CYC - 5) @(posedge clk);
    #1;
    `CHK(pst, PRS_PK_WAITING)
    repeat (10) @(posedge clk);
    #1;
    `CHK(pst, PRS_PK_ABORTED)
    $display("test abort and timeout done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_status;
    t_resume;
    t_abort_timeout;
    finish_test;
  end

  // cuts a hang short well inside the cycle allowance
  initial begin
    repeat (50000) @(posedge clk);
    `CHK(1'b1, 1'b0)
    finish_test;
  end
endmodule
